// *** rtl/lec_err_counters.sv ***
// per lane saturating error counters, one per error kind
`timescale 1ns/10ps
`default_nettype none
module lec_err_counters #(
  parameter int LANES = 8,
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // error events from the lane decoders
  input  wire lec_pkg::lec_err_evt_t evt,
  // all count values, lane-major
  output logic [LANES-1:0][CNT_W-1:0] disparity_error_count,
  output logic [LANES-1:0][CNT_W-1:0] not_in_table_count,
  output logic [LANES-1:0][CNT_W-1:0] unexpected_control_count
);

  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // next values of every counter
  logic [LANES-1:0][CNT_W-1:0] disp_d;
  logic [LANES-1:0][CNT_W-1:0] nit_d;
  logic [LANES-1:0][CNT_W-1:0] ucc_d;

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      // saturate instead of wrap so a busy lane never looks clean
      always_comb begin
        disp_d[g] = disparity_error_count[g];
        nit_d[g]  = not_in_table_count[g];
        ucc_d[g]  = unexpected_control_count[g];
        if (evt.disparity[g] && disparity_error_count[g] != CNT_MAX) begin
          disp_d[g] = disparity_error_count[g] + 1'b1;
        end
        if (evt.not_in_table[g] && not_in_table_count[g] != CNT_MAX) begin
          nit_d[g] = not_in_table_count[g] + 1'b1;
        end
        if (evt.unexp_ctrl[g] && unexpected_control_count[g] != CNT_MAX) begin
          ucc_d[g] = unexpected_control_count[g] + 1'b1;
        end
      end

      // register stage, cleared only by reset
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          disparity_error_count[g]    <= '0;
          not_in_table_count[g]       <= '0;
          unexpected_control_count[g] <= '0;
        end else begin
          disparity_error_count[g]    <= disp_d[g];
          not_in_table_count[g]       <= nit_d[g];
          unexpected_control_count[g] <= ucc_d[g];
        end
      end
    end
  endgenerate

endmodule // lec_err_counters
`default_nettype wire

// *** rtl/lec_pkg.sv ***
// shared constants and carrier types for the link error counter register bank
package lec_pkg;

  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANES  = 8;

  // register offsets, byte addresses of the control port
  localparam logic [11:0] OFS_LANE0_CONFIG_CHECKSUM = 12'h45D;
  localparam logic [11:0] OFS_ERROR_COUNTER_MONITOR = 12'h46B;
  localparam logic [11:0] OFS_PER_LANE_ALIGN_ENABLE = 12'h46C;

  // reset values
  localparam logic [7:0] RST_LANE0_CONFIG_CHECKSUM = 8'h45;
  localparam logic [7:0] RST_COUNTER_READBACK      = 8'h00;
  localparam logic [7:0] RST_PER_LANE_ALIGN_ENABLE = 8'h0F;
  localparam logic [2:0] RST_COUNTER_LANE_PICK     = 3'h0;
  localparam logic [1:0] RST_COUNTER_TYPE_PICK     = 2'h0;

  // field positions inside the monitor register
  localparam int LANE_PICK_LSB = 4;
  localparam int LANE_PICK_MSB = 6;
  localparam int TYPE_PICK_LSB = 0;
  localparam int TYPE_PICK_MSB = 1;

  // half of the lanes, used per link in dual link mode
  localparam int HALF_LANES = 4;

  // counter type codes written to the type pick field
  typedef enum logic [1:0] {
    CNT_DISPARITY   = 2'h0,
    CNT_NOT_IN_TBL  = 2'h1,
    CNT_UNEXP_CTRL  = 2'h2,
    CNT_UNUSED      = 2'h3
  } lec_cnt_type_t;

  // one error event per lane per kind, single cycle pulses
  typedef struct packed {
    logic [LANES-1:0] disparity;
    logic [LANES-1:0] not_in_table;
    logic [LANES-1:0] unexp_ctrl;
  } lec_err_evt_t;

  // register access request from the serial control port engine
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lec_reg_req_t;

endpackage : lec_pkg

// *** rtl/lec_regs.sv ***
// link error counter register bank: checksum, counter monitor, lane align enables
// What this block does
// - write-only lane pick field at bits 6:4
// - write-only counter type pick at bits 1:0
// - three error counters kept per lane
// - write picks first, then read selected count
// - readback is read-only, eight bits, resets zero
// - per lane align enables, lanes 0-3 after reset
// - dual link uses low four bits per link
`timescale 1ns/10ps
`default_nettype none
module lec_regs #(
  parameter int LANES = 8,
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // register port from the serial control port engine
  input  wire lec_pkg::lec_reg_req_t REG_REQ,
  output logic [7:0]                 RD_DATA,
  output logic                       RD_VALID,
  // error events from the lane decoders, same clock
  input  wire lec_pkg::lec_err_evt_t ERR_EVT,
  // link mode, same clock
  input  wire logic                  DUAL_LINK,
  // configuration outputs to the receive datapath
  output logic [LANES-1:0]           ALIGN_EN,
  output logic [7:0]                 FIRST_LANE_SUM
);

  // counter values from the counter bank
  logic [LANES-1:0][CNT_W-1:0] disparity_error_count;
  logic [LANES-1:0][CNT_W-1:0] not_in_table_count;
  logic [LANES-1:0][CNT_W-1:0] unexpected_control_count;

  // register state and next values
  logic [7:0]       first_lane_sum_q,  first_lane_sum_d;   // checksum register
  logic [2:0]       counter_lane_pick_q, counter_lane_pick_d; // write-only lane pick
  logic [1:0]       counter_type_pick_q, counter_type_pick_d; // write-only type pick
  logic [7:0]       counter_readback_q, counter_readback_d;   // read-only snapshot
  logic [7:0]       align_enable_q,    align_enable_d;     // per lane align enables
  logic [LANES-1:0] align_out_q,       align_out_d;        // enables seen by datapath
  logic [7:0]       rd_data_q,         rd_data_d;          // read answer
  logic             rd_valid_q,        rd_valid_d;         // read answer strobe

  // decode of the three addresses
  logic hit_sum;
  logic hit_mon;
  logic hit_aln;
  logic [7:0] sel_count;   // counter picked by the current selections

  // counter bank, indirect access only
  lec_err_counters #(
    .LANES (LANES),
    .CNT_W (CNT_W)
  ) u_counters (
    .clk                      (CLK),
    .rst_n                    (RST_N),
    .evt                      (ERR_EVT),
    .disparity_error_count    (disparity_error_count),
    .not_in_table_count       (not_in_table_count),
    .unexpected_control_count (unexpected_control_count)
  );

  // address decode
  always_comb begin
    hit_sum = (REG_REQ.addr == lec_pkg::OFS_LANE0_CONFIG_CHECKSUM);
    hit_mon = (REG_REQ.addr == lec_pkg::OFS_ERROR_COUNTER_MONITOR);
    hit_aln = (REG_REQ.addr == lec_pkg::OFS_PER_LANE_ALIGN_ENABLE);
  end

  // counter mux driven by the registered picks
  always_comb begin
    sel_count = '0;
    unique case (lec_pkg::lec_cnt_type_t'(counter_type_pick_q))
      lec_pkg::CNT_DISPARITY: begin
        sel_count = 8'(disparity_error_count[counter_lane_pick_q]);
      end
      lec_pkg::CNT_NOT_IN_TBL: begin
        sel_count = 8'(not_in_table_count[counter_lane_pick_q]);
      end
      lec_pkg::CNT_UNEXP_CTRL: begin
        sel_count = 8'(unexpected_control_count[counter_lane_pick_q]);
      end
      lec_pkg::CNT_UNUSED: begin
        sel_count = '0;
      end
    endcase
  end

  // register writes and readback snapshot
  always_comb begin
    first_lane_sum_d    = first_lane_sum_q;
    counter_lane_pick_d = counter_lane_pick_q;
    counter_type_pick_d = counter_type_pick_q;
    align_enable_d      = align_enable_q;
    // snapshot follows the picks one cycle later, so a read right after
    // the pick write still sees the old lane: leave one idle cycle
    counter_readback_d  = sel_count;
    if (REG_REQ.wr) begin
      if (hit_sum) begin
        // hardware takes the value as given; the sum is software's job
        first_lane_sum_d = REG_REQ.wdata;
      end
      if (hit_mon) begin
        // only the pick fields take the write, never the counters
        counter_lane_pick_d =
          REG_REQ.wdata[lec_pkg::LANE_PICK_MSB:lec_pkg::LANE_PICK_LSB];
        counter_type_pick_d =
          REG_REQ.wdata[lec_pkg::TYPE_PICK_MSB:lec_pkg::TYPE_PICK_LSB];
      end
      if (hit_aln) begin
        align_enable_d = REG_REQ.wdata;
      end
    end
  end

  // lane enables as seen by the datapath; both links share the low nibble
  always_comb begin
    align_out_d = align_enable_q;
    if (DUAL_LINK) begin
      align_out_d = {align_enable_q[lec_pkg::HALF_LANES-1:0],
                     align_enable_q[lec_pkg::HALF_LANES-1:0]};
    end
  end

  // read answer, one cycle after the request
  always_comb begin
    rd_valid_d = REG_REQ.rd;
    rd_data_d  = '0;
    if (REG_REQ.rd) begin
      if (hit_sum) begin
        rd_data_d = first_lane_sum_q;
      end else if (hit_mon) begin
        rd_data_d = counter_readback_q;
      end else if (hit_aln) begin
        rd_data_d = align_enable_q;
      end
    end
  end

  // state registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      first_lane_sum_q    <= lec_pkg::RST_LANE0_CONFIG_CHECKSUM;
      counter_lane_pick_q <= lec_pkg::RST_COUNTER_LANE_PICK;
      counter_type_pick_q <= lec_pkg::RST_COUNTER_TYPE_PICK;
      counter_readback_q  <= lec_pkg::RST_COUNTER_READBACK;
      align_enable_q      <= lec_pkg::RST_PER_LANE_ALIGN_ENABLE;
      align_out_q         <= LANES'(lec_pkg::RST_PER_LANE_ALIGN_ENABLE);
      rd_data_q           <= '0;
      rd_valid_q          <= 1'b0;
    end else begin
      first_lane_sum_q    <= first_lane_sum_d;
      counter_lane_pick_q <= counter_lane_pick_d;
      counter_type_pick_q <= counter_type_pick_d;
      counter_readback_q  <= counter_readback_d;
      align_enable_q      <= align_enable_d;
      align_out_q         <= align_out_d;
      rd_data_q           <= rd_data_d;
      rd_valid_q          <= rd_valid_d;
    end
  end

  // outputs straight from flops
  assign RD_DATA        = rd_data_q;
  assign RD_VALID       = rd_valid_q;
  assign ALIGN_EN       = align_out_q;
  assign FIRST_LANE_SUM = first_lane_sum_q;

endmodule // lec_regs
`default_nettype wire

// *** testbench/lec_far_tx.sv ***
// lane error source standing in for the far link transmitter
`timescale 1ns/10ps
`default_nettype none
module lec_far_tx (
  // clock
  input  wire logic                 clk,
  // error flags toward the bank, held until the next emit
  output var lec_pkg::lec_err_evt_t evt
);
  // quiet until told otherwise
  initial evt = '0;
  // launch flags just after an edge; they hold until the next emit
  task automatic emit(input lec_pkg::lec_err_evt_t e);
    @(posedge clk);
    evt <= e;
  endtask
endmodule // lec_far_tx
`default_nettype wire

// *** testbench/lec_regs_bench.sv ***
// self-checking bench for the link error counter register bank
`timescale 1ns/10ps
`default_nettype none
module lec_regs_bench;
  localparam logic [11:0] SUM_A = lec_pkg::OFS_LANE0_CONFIG_CHECKSUM;
  localparam logic [11:0] MON_A = lec_pkg::OFS_ERROR_COUNTER_MONITOR;
  localparam logic [11:0] ALN_A = lec_pkg::OFS_PER_LANE_ALIGN_ENABLE;
  logic                  clk;          // 100 ns clock
  logic                  rst_n;        // synchronous, active low
  lec_pkg::lec_reg_req_t req;          // register request
  lec_pkg::lec_err_evt_t evt;          // flags from far side
  logic                  dual_link;    // link mode
  logic [7:0]            rd_data;      // read answer
  logic                  rd_valid;     // answer strobe
  logic [7:0]            align_en;     // lane align enables
  logic [7:0]            lane_sum;     // stored checksum
  int                    error_cnt;    // mismatches
  int                    total_checks; // comparisons
  int                    cycles = 0;   // hang guard
  lec_regs u_lec_regs (.CLK(clk), .RST_N(rst_n), .REG_REQ(req), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .ERR_EVT(evt), .DUAL_LINK(dual_link), .ALIGN_EN(align_en),
    .FIRST_LANE_SUM(lane_sum));
  lec_far_tx u_lec_far_tx (.clk(clk), .evt(evt));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  // read; the answer must stand in the cycle right after the strobe edge
  task automatic rdc(input logic [11:0] a, input logic [7:0] want);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    check("rd_valid", {7'h00, rd_valid}, 8'h01);
    check($sformatf("read %h", a), rd_data, want);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // whole run needs about 520 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    lec_pkg::lec_err_evt_t e;
    logic [7:0] sum;
    rst_n = 1'b0;
    req = '0;
    dual_link = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    sum = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdc(SUM_A, 8'h45);
    rdc(ALN_A, 8'h0F);
    rdc(MON_A, 8'h00);
    rdc(12'h46A, 8'h00);
    wr(ALN_A, 8'hA5);
    rdc(ALN_A, 8'hA5);
    check("align_en", align_en, 8'hA5);
    @(posedge clk);
    dual_link <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("align_en dual", align_en, 8'h55);
    rdc(ALN_A, 8'hA5);
    @(posedge clk);
    dual_link <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("align_en single", align_en, 8'hA5);
    // config bytes land outside this bank; only their sum is kept here
    for (int i = 0; i < 13; i++) begin
      wr(12'h450 + 12'(i), 8'(i * 29 + 3));
      sum = sum + 8'(i * 29 + 3);
    end
    wr(SUM_A, sum);
    rdc(SUM_A, sum);
    check("lane_sum", lane_sum, sum);
    // lane l of kind k sees l + 8k + 1 errors
    for (int n = 0; n < 24; n++) begin
      for (int l = 0; l < 8; l++) begin
        e.disparity[l] = (l + 1 > n);
        e.not_in_table[l] = (l + 9 > n);
        e.unexp_ctrl[l] = (l + 17 > n);
      end
      u_lec_far_tx.emit(e);
    end
    u_lec_far_tx.emit('0);
    repeat (3) @(posedge clk);
    // reserved bits set on purpose, they must not disturb the picks
    for (int l = 0; l < 8; l++) begin
      for (int k = 0; k < 4; k++) begin
        wr(MON_A, {1'b1, 3'(l), 2'b11, 2'(k)});
        rdc(MON_A, (k == 3) ? 8'h00 : 8'(l + 8 * k + 1));
      end
    end
    // counts stop at full scale instead of wrapping
    for (int n = 0; n < 300; n++)
      u_lec_far_tx.emit('{disparity: 8'h80, not_in_table: 8'h00, unexp_ctrl: 8'h00});
    u_lec_far_tx.emit('0);
    wr(MON_A, 8'h70);
    rdc(MON_A, 8'hFF);
    tally_and_finish();
  end
endmodule // lec_regs_bench
`default_nettype wire

// *** testbench/lec_regs_props.sv ***
// port checker for the link error counter register bank
`timescale 1ns/10ps
`default_nettype none
module lec_regs_props #(
  parameter int LANES = 8
) (
  // clock and reset
  input wire logic                  CLK,
  input wire logic                  RST_N,
  // register port
  input wire lec_pkg::lec_reg_req_t REG_REQ,
  input wire logic [7:0]            RD_DATA,
  input wire logic                  RD_VALID,
  // events, mode and outputs
  input wire lec_pkg::lec_err_evt_t ERR_EVT,
  input wire logic                  DUAL_LINK,
  input wire logic [LANES-1:0]      ALIGN_EN,
  input wire logic [7:0]            FIRST_LANE_SUM
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // address decodes of the request
  logic sum_wr, aln_wr, bad_rd;
  assign sum_wr = REG_REQ.wr && REG_REQ.addr == lec_pkg::OFS_LANE0_CONFIG_CHECKSUM;
  assign aln_wr = REG_REQ.wr && REG_REQ.addr == lec_pkg::OFS_PER_LANE_ALIGN_ENABLE;
  assign bad_rd = REG_REQ.rd && REG_REQ.addr != lec_pkg::OFS_LANE0_CONFIG_CHECKSUM
    && REG_REQ.addr != lec_pkg::OFS_ERROR_COUNTER_MONITOR
    && REG_REQ.addr != lec_pkg::OFS_PER_LANE_ALIGN_ENABLE;
  // monitor register traffic, picks in and readback out
  logic mon_wr, mon_rd;
  assign mon_wr = REG_REQ.wr && REG_REQ.addr == lec_pkg::OFS_ERROR_COUNTER_MONITOR;
  assign mon_rd = REG_REQ.rd && REG_REQ.addr == lec_pkg::OFS_ERROR_COUNTER_MONITOR;
  // unused type code picked, one quiet cycle for the snapshot, then the read
  sequence s_type3_rd;
    (mon_wr && REG_REQ.wdata[1:0] == 2'h3) ##1 !mon_wr ##1 mon_rd;
  endsequence
  property p_type3_zero; s_type3_rd |=> RD_DATA == 8'h00; endproperty
  // a write followed by a quiet cycle, so no later write overtakes it
  sequence s_sum_wr; sum_wr ##1 !sum_wr; endsequence
  sequence s_aln_wr; (aln_wr && !DUAL_LINK) ##1 (!aln_wr && !DUAL_LINK); endsequence
  property p_rd_ans; REG_REQ.rd |=> RD_VALID; endproperty
  property p_no_ans; !REG_REQ.rd |=> !RD_VALID; endproperty
  property p_idle_zero; !RD_VALID |-> RD_DATA == 8'h00; endproperty
  property p_unmapped; bad_rd |=> RD_DATA == 8'h00; endproperty
  property p_sum_wr; s_sum_wr |=> FIRST_LANE_SUM == $past(REG_REQ.wdata, 2); endproperty
  property p_sum_hold; !sum_wr ##1 !sum_wr |=> $stable(FIRST_LANE_SUM); endproperty
  property p_aln_wr; s_aln_wr |=> ALIGN_EN == $past(REG_REQ.wdata, 2); endproperty
  // reset edge excluded: the enables leave reset at their single link value
  property p_dual;
    DUAL_LINK && $past(DUAL_LINK) && $past(RST_N) |-> ALIGN_EN[7:4] == ALIGN_EN[3:0];
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_no_ans: assert property (p_no_ans) else $error("answer without read");
  a_idle_zero: assert property (p_idle_zero) else $error("idle read data");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  a_sum_wr: assert property (p_sum_wr) else $error("checksum not stored");
  a_sum_hold: assert property (p_sum_hold) else $error("checksum moved");
  a_aln_wr: assert property (p_aln_wr) else $error("align enable not stored");
  a_dual: assert property (p_dual) else $error("dual link nibbles differ");
  a_type3_zero: assert property (p_type3_zero) else $error("unused type read not zero");
endmodule // lec_regs_props
bind lec_regs lec_regs_props #(.LANES(LANES)) u_lec_regs_props (.CLK(CLK), .RST_N(RST_N),
  .REG_REQ(REG_REQ), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .ERR_EVT(ERR_EVT),
  .DUAL_LINK(DUAL_LINK), .ALIGN_EN(ALIGN_EN), .FIRST_LANE_SUM(FIRST_LANE_SUM));
`default_nettype wire
